/* rtl/ptrc_timer.sv */
// Periodic 10-bit timer with APB register file, compare, capture and PWM output
//
// Operation
// - Pause holds count, resume continues
// - Clock select picks count clock source
// - On rising clears count; falling stops, holds
// - On rising restores initial output level in compare mode
// - Mode field selects operating mode
// - Compare match A drives output action
// - PWM mode output function selection
// - Capture mode edge selection
// - Same requested level gives no change
// - Output control bit meaning per mode
// - Polarity bit inverts output pin
// - Capture source pin selection
// - Clear select picks A or P clear
// - Overflow clear only with period zero
// - Clear select ignored in PWM, capture
// - Counter readable as two bytes
// - Compare A value two bytes, reset zero
// - Period value two bytes, reset zero
// - 10-bit up counter, full comparators
// - A clearing raises only A flag
`timescale 1ns/1ns
`default_nettype none
module ptrc_timer (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [ptrc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [ptrc_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [ptrc_pkg::DATA_W-1:0]  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         timer_io_pin_i,
  output logic                              timer_io_pin_o,
  output logic                              timer_io_pin_oe,
  input  wire logic                         external_count_pin,
  input  wire logic                         sub_clock_pin,
  output logic                              compare_a_flag,
  output logic                              compare_p_flag
);
  import ptrc_pkg::*;

  // Control fields
  logic              count_pause_reg;           // Counter pause
  ptrc_cksel_t       count_clock_select_reg;    // Count clock source
  logic              timer_on_reg;              // Timer on/off
  ptrc_mode_t        operating_mode_select_reg; // Operating mode
  logic [1:0]        output_function_select_reg;// Pin function per mode
  logic              output_initial_control_reg;// Initial/active level
  logic              output_polarity_reg;       // Output inversion
  logic              capture_source_select_reg; // Capture trigger pin
  logic              clear_source_select_reg;   // Clear by A or by P
  // Data registers
  logic [CNT_W-1:0]  compare_a_value_reg;       // Comparator A value
  logic [CNT_W-1:0]  period_compare_value_reg;  // Comparator P value
  logic [CNT_W-1:0]  count_reg;                 // Up-counter
  // Internal state
  logic              on_prev_reg;               // Last on value for edges
  logic              out_lvl_reg;               // Output level before polarity
  logic              flag_a_reg;                // Comparator A event flag
  logic              flag_p_reg;                // Comparator P event flag
  logic [5:0]        div_reg;                   // Free-running prescaler
  logic [DATA_W-1:0] prdata_reg;                // Read data holder

  // Synchronised pins
  logic [NPINS-1:0]  pin_raw;
  logic [NPINS-1:0]  pin_lvl;
  logic [NPINS-1:0]  pin_rise;
  logic [NPINS-1:0]  pin_fall;

  // Decoded events
  logic              tick;        // Selected count clock pulse
  logic              run;         // Counter advances this cycle
  logic [CNT_W-1:0]  count_inc;   // Counter plus one
  logic              match_a;     // Comparator A match
  logic              match_p;     // Comparator P match or overflow
  logic              clear_cnt;   // Counter clears instead of advancing
  logic              on_rise;     // On bit went low to high
  logic              sp_mode;     // Single pulse selected
  logic              cap_rise;    // Capture source rising
  logic              cap_fall;    // Capture source falling
  logic              cap_evt;     // Capture takes place
  logic              sp_trigger;  // External pin starts single pulse
  logic              out_lvl_next;
  logic              drives_pin;  // Mode controls the pin

  // APB decode
  logic              apb_setup;
  logic              apb_wr;

  // Returns one when the address hits the given offset
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    addr_is = (a == off);
  endfunction : addr_is

  // Returns one when the address names any register
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = addr_is(a, OFF_CTRL0)  | addr_is(a, OFF_CTRL1)  |
                  addr_is(a, OFF_CNT_LO) | addr_is(a, OFF_CNT_HI) |
                  addr_is(a, OFF_CMPA_L) | addr_is(a, OFF_CMPA_H) |
                  addr_is(a, OFF_PER_L)  | addr_is(a, OFF_PER_H)  |
                  addr_is(a, OFF_FLAGS);
  endfunction : addr_mapped

  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite & pstrb[0];

  // Slave always answers in the access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_mapped(paddr);
  assign prdata  = prdata_reg;

  // Pin synchronisers, one per external input
  assign pin_raw = {sub_clock_pin, external_count_pin, timer_io_pin_i};
  generate
    for (genvar i = 0; i < NPINS; i++) begin : g_sync
      ptrc_sync_edge u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (pin_raw[i]),
        .level   (pin_lvl[i]),
        .rise    (pin_rise[i]),
        .fall    (pin_fall[i])
      );
    end
  endgenerate

  // Prescaler for the divided count clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 6'h00;
    end else begin
      div_reg <= div_reg + 6'h01;
    end
  end

  // Count clock selection
  always_comb begin
    unique case (count_clock_select_reg)
      PTRC_CK_SYS4: tick = ((div_reg & DIV4_MASK) == DIV4_MASK);
      PTRC_CK_SYS:  tick = 1'b1;
      PTRC_CK_H16:  tick = ((div_reg & DIV16_MASK) == DIV16_MASK);
      PTRC_CK_H64:  tick = (div_reg == DIV64_MASK);
      PTRC_CK_SUB0: tick = pin_rise[PIN_SUB];
      PTRC_CK_SUB1: tick = pin_rise[PIN_SUB];
      PTRC_CK_EXTR: tick = pin_rise[PIN_EXT];
      PTRC_CK_EXTF: tick = pin_fall[PIN_EXT];
    endcase
  end

  // Counter advance, compare and clear decisions
  assign on_rise   = timer_on_reg & ~on_prev_reg;
  assign run       = timer_on_reg & ~count_pause_reg & tick;
  assign count_inc = count_reg + 10'h001;
  assign sp_mode   = (operating_mode_select_reg == PTRC_MODE_PWM) &
                     (output_function_select_reg == 2'b11);
  // Comparator A value of zero never matches in compare or timer modes
  assign match_a   = run & (count_inc == compare_a_value_reg) &
                     ((compare_a_value_reg != 10'h000) |
                      (operating_mode_select_reg == PTRC_MODE_PWM));
  // Period zero makes the match fall on the overflow wrap
  assign match_p   = run & (count_inc == period_compare_value_reg);

  // Clear source per mode
  always_comb begin
    unique case (operating_mode_select_reg)
      PTRC_MODE_CMP,
      PTRC_MODE_TMR: clear_cnt = clear_source_select_reg ? match_a : match_p;
      PTRC_MODE_PWM: clear_cnt = sp_mode ? 1'b0 : match_p;
      PTRC_MODE_CAP: clear_cnt = match_p;
    endcase
  end

  // Counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg   <= RST_CNT;
      on_prev_reg <= 1'b0;
    end else begin
      on_prev_reg <= timer_on_reg;
      if (on_rise) begin
        count_reg <= RST_CNT;
      end else if (run) begin
        count_reg <= clear_cnt ? RST_CNT : count_inc;
      end
      // Otherwise held while off or paused
    end
  end

  // Capture source and edge choice
  assign cap_rise = capture_source_select_reg ? pin_rise[PIN_EXT] : pin_rise[PIN_IO];
  assign cap_fall = capture_source_select_reg ? pin_fall[PIN_EXT] : pin_fall[PIN_IO];
  always_comb begin
    cap_evt = 1'b0;
    if (timer_on_reg && operating_mode_select_reg == PTRC_MODE_CAP) begin
      unique case (output_function_select_reg)
        2'b00: cap_evt = cap_rise;
        2'b01: cap_evt = cap_fall;
        2'b10: cap_evt = cap_rise | cap_fall;
        2'b11: cap_evt = 1'b0;
      endcase
    end
  end

  // Single pulse start from the external pin active edge
  assign sp_trigger = sp_mode & ~timer_on_reg & pin_rise[PIN_EXT];

  // Control register 0, including hardware set and clear of the on bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_pause_reg        <= RST_CTRL0[F_PAUSE];
      count_clock_select_reg <= ptrc_cksel_t'(RST_CTRL0[F_CKSEL_H:F_CKSEL_L]);
      timer_on_reg           <= RST_CTRL0[F_ON];
    end else if (apb_wr && addr_is(paddr, OFF_CTRL0)) begin
      count_pause_reg        <= pwdata[F_PAUSE];
      count_clock_select_reg <= ptrc_cksel_t'(pwdata[F_CKSEL_H:F_CKSEL_L]);
      timer_on_reg           <= pwdata[F_ON];
    end else if (sp_mode && match_a) begin
      timer_on_reg <= 1'b0; // Pulse ends on comparator A
    end else if (sp_trigger) begin
      timer_on_reg <= 1'b1; // Pulse starts from pin edge
    end
  end

  // Control register 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operating_mode_select_reg  <= ptrc_mode_t'(RST_CTRL1[F_MODE_H:F_MODE_L]);
      output_function_select_reg <= RST_CTRL1[F_FUNC_H:F_FUNC_L];
      output_initial_control_reg <= RST_CTRL1[F_INIT];
      output_polarity_reg        <= RST_CTRL1[F_POL];
      capture_source_select_reg  <= RST_CTRL1[F_CAPSRC];
      clear_source_select_reg    <= RST_CTRL1[F_CLRSEL];
    end else if (apb_wr && addr_is(paddr, OFF_CTRL1)) begin
      operating_mode_select_reg  <= ptrc_mode_t'(pwdata[F_MODE_H:F_MODE_L]);
      output_function_select_reg <= pwdata[F_FUNC_H:F_FUNC_L];
      output_initial_control_reg <= pwdata[F_INIT];
      output_polarity_reg        <= pwdata[F_POL];
      capture_source_select_reg  <= pwdata[F_CAPSRC];
      clear_source_select_reg    <= pwdata[F_CLRSEL];
    end
  end

  // Comparator A value; a capture wins over a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_a_value_reg <= RST_CNT;
    end else if (cap_evt) begin
      compare_a_value_reg <= count_reg;
    end else if (apb_wr && addr_is(paddr, OFF_CMPA_L)) begin
      compare_a_value_reg[7:0] <= pwdata[7:0];
    end else if (apb_wr && addr_is(paddr, OFF_CMPA_H)) begin
      compare_a_value_reg[9:8] <= pwdata[1:0];
    end
  end

  // Comparator P period value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_compare_value_reg <= RST_CNT;
    end else if (apb_wr && addr_is(paddr, OFF_PER_L)) begin
      period_compare_value_reg[7:0] <= pwdata[7:0];
    end else if (apb_wr && addr_is(paddr, OFF_PER_H)) begin
      period_compare_value_reg[9:8] <= pwdata[1:0];
    end
  end

  // Event flags: hardware set wins over software write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_a_reg <= 1'b0;
      flag_p_reg <= 1'b0;
    end else begin
      if ((match_a && operating_mode_select_reg != PTRC_MODE_CAP) || cap_evt) begin
        flag_a_reg <= 1'b1;
      end else if (apb_wr && addr_is(paddr, OFF_FLAGS) && pwdata[F_FLAG_A]) begin
        flag_a_reg <= 1'b0;
      end
      // No P flag when A clears the counter, nor in single pulse
      if (match_p && !sp_mode &&
          !(clear_source_select_reg &&
            (operating_mode_select_reg == PTRC_MODE_CMP ||
             operating_mode_select_reg == PTRC_MODE_TMR))) begin
        flag_p_reg <= 1'b1;
      end else if (apb_wr && addr_is(paddr, OFF_FLAGS) && pwdata[F_FLAG_P]) begin
        flag_p_reg <= 1'b0;
      end
    end
  end

  assign compare_a_flag = flag_a_reg;
  assign compare_p_flag = flag_p_reg;

  // Output level before polarity, per mode
  always_comb begin
    out_lvl_next = out_lvl_reg;
    unique case (operating_mode_select_reg)
      PTRC_MODE_CMP: begin
        if (on_rise) begin
          out_lvl_next = output_initial_control_reg;
        end else if (match_a) begin
          unique case (output_function_select_reg)
            2'b00: out_lvl_next = out_lvl_reg;
            2'b01: out_lvl_next = 1'b0;
            2'b10: out_lvl_next = 1'b1;
            2'b11: out_lvl_next = ~out_lvl_reg;
          endcase
        end
      end
      PTRC_MODE_PWM: begin
        unique case (output_function_select_reg)
          2'b00: out_lvl_next = ~output_initial_control_reg;
          2'b01: out_lvl_next = output_initial_control_reg;
          // Duty at or above period gives full active level
          2'b10: out_lvl_next = (count_reg < compare_a_value_reg) ?
                                output_initial_control_reg :
                                ~output_initial_control_reg;
          // On rising shows the active level until the on bit falls
          2'b11: out_lvl_next = (timer_on_reg && !(sp_mode && match_a)) ?
                                output_initial_control_reg :
                                ~output_initial_control_reg;
        endcase
      end
      PTRC_MODE_CAP,
      PTRC_MODE_TMR: out_lvl_next = out_lvl_reg;
    endcase
  end

  // Output level register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_lvl_reg <= 1'b0;
    end else begin
      out_lvl_reg <= out_lvl_next;
    end
  end

  // Pin drive: only compare and PWM modes own the pin
  assign drives_pin      = (operating_mode_select_reg == PTRC_MODE_CMP) |
                           (operating_mode_select_reg == PTRC_MODE_PWM);
  assign timer_io_pin_o  = out_lvl_reg ^ output_polarity_reg;
  assign timer_io_pin_oe = drives_pin;

  // Read data is captured in the setup cycle and shown in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_reg <= 32'h0000_0000;
      if (addr_is(paddr, OFF_CTRL0)) begin
        prdata_reg[F_PAUSE]             <= count_pause_reg;
        prdata_reg[F_CKSEL_H:F_CKSEL_L] <= count_clock_select_reg;
        prdata_reg[F_ON]                <= timer_on_reg;
      end else if (addr_is(paddr, OFF_CTRL1)) begin
        prdata_reg[F_MODE_H:F_MODE_L]   <= operating_mode_select_reg;
        prdata_reg[F_FUNC_H:F_FUNC_L]   <= output_function_select_reg;
        prdata_reg[F_INIT]              <= output_initial_control_reg;
        prdata_reg[F_POL]               <= output_polarity_reg;
        prdata_reg[F_CAPSRC]            <= capture_source_select_reg;
        prdata_reg[F_CLRSEL]            <= clear_source_select_reg;
      end else if (addr_is(paddr, OFF_CNT_LO)) begin
        prdata_reg[7:0] <= count_reg[7:0];
      end else if (addr_is(paddr, OFF_CNT_HI)) begin
        prdata_reg[1:0] <= count_reg[9:8];
      end else if (addr_is(paddr, OFF_CMPA_L)) begin
        prdata_reg[7:0] <= compare_a_value_reg[7:0];
      end else if (addr_is(paddr, OFF_CMPA_H)) begin
        prdata_reg[1:0] <= compare_a_value_reg[9:8];
      end else if (addr_is(paddr, OFF_PER_L)) begin
        prdata_reg[7:0] <= period_compare_value_reg[7:0];
      end else if (addr_is(paddr, OFF_PER_H)) begin
        prdata_reg[1:0] <= period_compare_value_reg[9:8];
      end else if (addr_is(paddr, OFF_FLAGS)) begin
        prdata_reg[F_FLAG_A] <= flag_a_reg;
        prdata_reg[F_FLAG_P] <= flag_p_reg;
      end
    end
  end

endmodule : ptrc_timer
`default_nettype wire

/* rtl/ptrc_pkg.sv */
// Package of offsets, fields, reset values and counts for the periodic timer block
package ptrc_pkg;

  // Bus and counter widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CNT_W  = 10;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL0  = 8'h00;
  localparam logic [7:0] OFF_CTRL1  = 8'h04;
  localparam logic [7:0] OFF_CNT_LO = 8'h08;
  localparam logic [7:0] OFF_CNT_HI = 8'h0c;
  localparam logic [7:0] OFF_CMPA_L = 8'h10;
  localparam logic [7:0] OFF_CMPA_H = 8'h14;
  localparam logic [7:0] OFF_PER_L  = 8'h18;
  localparam logic [7:0] OFF_PER_H  = 8'h1c;
  localparam logic [7:0] OFF_FLAGS  = 8'h20;

  // Control 0 field positions
  localparam int F_PAUSE   = 7;
  localparam int F_CKSEL_H = 6;
  localparam int F_CKSEL_L = 4;
  localparam int F_ON      = 3;
  // Control 1 field positions
  localparam int F_MODE_H  = 7;
  localparam int F_MODE_L  = 6;
  localparam int F_FUNC_H  = 5;
  localparam int F_FUNC_L  = 4;
  localparam int F_INIT    = 3;
  localparam int F_POL     = 2;
  localparam int F_CAPSRC  = 1;
  localparam int F_CLRSEL  = 0;
  // Flag register field positions
  localparam int F_FLAG_A  = 0;
  localparam int F_FLAG_P  = 1;

  // Values after reset
  localparam logic [7:0]       RST_CTRL0 = 8'h00;
  localparam logic [7:0]       RST_CTRL1 = 8'h00;
  localparam logic [CNT_W-1:0] RST_CNT   = 10'h000;

  // Prescaler terminal counts for the divided clocks
  localparam logic [5:0] DIV4_MASK  = 6'h03;
  localparam logic [5:0] DIV16_MASK = 6'h0f;
  localparam logic [5:0] DIV64_MASK = 6'h3f;

  // Synchronised pin indices
  localparam int PIN_IO  = 0;
  localparam int PIN_EXT = 1;
  localparam int PIN_SUB = 2;
  localparam int NPINS   = 3;

  // Operating modes
  typedef enum logic [1:0] {
    PTRC_MODE_CMP = 2'b00,
    PTRC_MODE_CAP = 2'b01,
    PTRC_MODE_PWM = 2'b10,
    PTRC_MODE_TMR = 2'b11
  } ptrc_mode_t;

  // Count clock selections
  typedef enum logic [2:0] {
    PTRC_CK_SYS4  = 3'b000,
    PTRC_CK_SYS   = 3'b001,
    PTRC_CK_H16   = 3'b010,
    PTRC_CK_H64   = 3'b011,
    PTRC_CK_SUB0  = 3'b100,
    PTRC_CK_SUB1  = 3'b101,
    PTRC_CK_EXTR  = 3'b110,
    PTRC_CK_EXTF  = 3'b111
  } ptrc_cksel_t;

endpackage : ptrc_pkg

/* rtl/ptrc_sync_edge.sv */
// Two-flop pin synchroniser with edge detection
`timescale 1ns/1ns
`default_nettype none
module ptrc_sync_edge (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_reg;  // First stage, read only by the second
  logic sync_reg;  // Second stage, safe to use
  logic prev_reg;  // Previous synced level for edges

  // Synchroniser chain and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edge outputs are one-cycle pulses
  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
  assign fall  = ~sync_reg & prev_reg;
endmodule : ptrc_sync_edge
`default_nettype wire

/* bench/ptrc_timer_monitor.sv */
// Port checker for the periodic timer block
`timescale 1ns/1ns
`default_nettype none
module ptrc_timer_monitor
  import ptrc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_io_pin_oe,
  input wire logic        compare_a_flag,
  input wire logic        compare_p_flag
);
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc  = psel && penable;                              // Access phase
  wire wr0  = acc && pwrite && pstrb[0];                    // Taken write
  wire clra = wr0 && paddr == OFF_FLAGS && pwdata[F_FLAG_A]; // Clear of flag A
  wire clrp = wr0 && paddr == OFF_FLAGS && pwdata[F_FLAG_P]; // Clear of flag P
  chk_ready_high: assert property (psel |-> pready)
    else $error("pready low in transfer");
  chk_err_access: assert property (pslverr |-> acc)
    else $error("pslverr outside access");
  chk_err_unmapped: assert property (acc && paddr > OFF_FLAGS |-> pslverr)
    else $error("unmapped address not refused");
  chk_err_mapped: assert property (acc && paddr <= OFF_FLAGS && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped address refused");
  chk_flag_a_hold: assert property (compare_a_flag && !clra |=> compare_a_flag)
    else $error("flag A lost");
  chk_flag_p_hold: assert property (compare_p_flag && !clrp |=> compare_p_flag)
    else $error("flag P lost");
  chk_oe_cause: assert property ($changed(timer_io_pin_oe) |-> $past(wr0 && paddr == OFF_CTRL1))
    else $error("pin enable moved without mode write");
  chk_oe_by_mode: assert property (wr0 && paddr == OFF_CTRL1 |=> timer_io_pin_oe == !$past(pwdata[F_MODE_L]))
    else $error("pin enable not per mode");
endmodule : ptrc_timer_monitor
`default_nettype wire

/* bench/ptrc_pins.sv */
// Far-side pin model: capture input, external count and sub clock pins
`timescale 1ns/1ns
`default_nettype none
module ptrc_pins (
  input  wire logic pclk,
  input  wire logic cap_req,
  input  wire logic ext_req,
  input  wire logic sub_req,
  input  wire logic timer_io_pin_o,
  input  wire logic timer_io_pin_oe,
  output logic      timer_io_pin_i,
  output var logic  external_count_pin = 1'b0,
  output var logic  sub_clock_pin = 1'b0
);
  logic cap_lvl = 1'b0; // Level the far side puts on the shared pin
  // Pins follow requests one clock later, as a board driver would
  always @(posedge pclk) begin
    cap_lvl <= cap_req;
    external_count_pin <= ext_req;
    sub_clock_pin <= sub_req;
  end
  // Shared pin: the timer wins while it drives, else the far side
  assign timer_io_pin_i = timer_io_pin_oe ? timer_io_pin_o : cap_lvl;
endmodule : ptrc_pins
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench of the periodic timer block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ptrc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, v, c1, seed = 32'hc;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, er, timer_io_pin_i, timer_io_pin_o, timer_io_pin_oe;
  logic        external_count_pin, sub_clock_pin, compare_a_flag, compare_p_flag;
  logic        cap_req = 0, ext_req = 0, sub_req = 0;
  int          bad_count = 0, checked = 0;
  ptrc_timer ptrc_timer_i (.*);
  ptrc_pins ptrc_pins_i (.*);
  always #2 pclk = ~pclk; // 250 MHz
  // Xorshift source of random data
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Pin level after a compare A match
  function automatic logic pin_exp(int f, logic init);
    return f == 0 ? init : f == 1 ? 1'b0 : f == 2 ? 1'b1 : !init;
  endfunction : pin_exp
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rdcnt(output logic [31:0] c);
    apb(0, OFF_CNT_HI, 0);
    c = rd << 8;
    apb(0, OFF_CNT_LO, 0);
    c = c | rd;
  endtask : rdcnt
  task automatic final_report();
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  initial begin
    #80000;
    bad_count++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 9; i++) begin
      apb(0, 8'(i * 4), 0);
      chk("reset", rd, 32'h0);
    end
    // Random compare and period bytes, then read-only counter and a hole
    for (int i = 4; i < 8; i++) begin
      v = rnd();
      apb(1, 8'(i * 4), v);
      apb(0, 8'(i * 4), 0);
      chk("rw", rd, v & (i[0] ? 32'h3 : 32'hff));
    end
    apb(1, OFF_CNT_LO, 32'hff);
    apb(0, OFF_CNT_LO, 0);
    chk("cnt_ro", rd, 32'h0);
    apb(0, 8'h40, 0);
    chk("hole", er, 32'h1);
    apb(1, OFF_PER_L, 0);
    apb(1, OFF_PER_H, 0);
    // On with pause clears, run, pause holds, off holds
    apb(1, OFF_CTRL0, 32'h98);
    rdcnt(c1);
    chk("on_clear", c1, 32'h0);
    apb(1, OFF_CTRL0, 32'h18);
    repeat (20) @(posedge pclk);
    apb(1, OFF_CTRL0, 32'h98);
    rdcnt(c1);
    repeat (10) @(posedge pclk);
    rdcnt(v);
    chk("pause", v, c1);
    apb(1, OFF_CTRL0, 32'h18);
    apb(1, OFF_CTRL0, 32'h10);
    rdcnt(v);
    chk("resume", 32'(v > c1 && v < c1 + 20), 32'h1);
    repeat (10) @(posedge pclk);
    rdcnt(c1);
    chk("off", c1, v);
    // Pin clock sources: rising, falling, sub clock
    for (int k = 0; k < 3; k++) begin
      apb(1, OFF_CTRL0, 32'h0);
      apb(1, OFF_CTRL0, {25'h0, k == 2 ? 3'b100 : {2'b11, k[0]}, 4'h8});
      repeat (3) begin
        if (k == 2) sub_req <= 1;
        else ext_req <= 1;
        repeat (6) @(posedge pclk);
        sub_req <= 0;
        ext_req <= 0;
        repeat (6) @(posedge pclk);
      end
      apb(1, OFF_CTRL0, 32'h0);
      rdcnt(v);
      chk("ext_cnt", v, 32'h3);
    end
    // Divided clock: system/4 ticks ten or eleven times in 42 running edges
    apb(1, OFF_CTRL0, 32'h08);
    repeat (40) @(posedge pclk);
    apb(1, OFF_CTRL0, 32'h0);
    rdcnt(v);
    chk("div4", 32'(v == 10 || v == 11), 32'h1);
    // Compare output per function, random initial level and polarity
    apb(1, OFF_CMPA_H, 32'h0);
    apb(1, OFF_CMPA_L, 32'h8);
    for (int f = 0; f < 4; f++) begin
      v = rnd() & 32'hc;
      apb(1, OFF_CTRL0, 32'h0);
      apb(1, OFF_CTRL1, v | 32'(f << 4));
      apb(1, OFF_FLAGS, 32'h3);
      apb(1, OFF_CTRL0, 32'h18);
      repeat (2) @(negedge pclk);
      chk("pin_init", timer_io_pin_o, v[3] ^ v[2]);
      repeat (30) @(negedge pclk);
      chk("pin_match", timer_io_pin_o, pin_exp(f, v[3]) ^ v[2]);
    end
    // Clear source: period 3 against compare A 100, then compare A 5 in timer mode
    for (int c = 0; c < 2; c++) begin
      apb(1, OFF_CTRL0, 32'h0);
      apb(1, OFF_CMPA_L, c ? 32'h5 : 32'h64);
      apb(1, OFF_PER_L, 32'h3);
      apb(1, OFF_CTRL1, c ? 32'hc1 : 32'h0);
      apb(1, OFF_FLAGS, 32'h3);
      apb(1, OFF_CTRL0, 32'h18);
      repeat (40) @(posedge pclk);
      apb(1, OFF_CTRL0, 32'h0);
      rdcnt(v);
      chk("cnt_bound", 32'(v < (c ? 5 : 3)), 32'h1);
      chk("flag_a", compare_a_flag, 32'(c));
      chk("flag_p", compare_p_flag, 32'(!c));
    end
    // Capture: every edge code, both sources, pulse on either pin
    for (int i = 0; i < 16; i++) begin
      apb(1, OFF_CTRL0, 32'h0);
      apb(1, OFF_CMPA_H, 32'h2);
      apb(1, OFF_CTRL1, 32'h40 | 32'((i & 3) << 4) | 32'((i & 4) >> 1));
      apb(1, OFF_FLAGS, 32'h3);
      apb(1, OFF_CTRL0, 32'h18);
      if (i[3]) ext_req <= 1;
      else cap_req <= 1;
      repeat (6) @(posedge pclk);
      cap_req <= 0;
      ext_req <= 0;
      repeat (6) @(negedge pclk);
      c1 = 32'(i[1:0] != 2'b11 && i[3] == i[2]);
      chk("capture", compare_a_flag, c1);
      apb(0, OFF_CMPA_H, 0);
      chk("cap_value", rd, c1 ? 32'h0 : 32'h2);
    end
    // Single pulse: software start, then pin start; match A ends it
    apb(1, OFF_CTRL0, 32'h0);
    apb(1, OFF_CMPA_H, 32'h0);
    apb(1, OFF_CMPA_L, 32'h5);
    apb(1, OFF_CTRL1, 32'hb8);
    for (int s = 0; s < 2; s++) begin
      apb(1, OFF_FLAGS, 32'h3);
      if (s == 0) apb(1, OFF_CTRL0, 32'h18);
      else ext_req <= 1;
      repeat (6) @(negedge pclk);
      chk("sp_active", timer_io_pin_o, 32'h1);
      @(posedge pclk);
      ext_req <= 0;
      repeat (6) @(negedge pclk);
      chk("sp_end", timer_io_pin_o, 32'h0);
      chk("sp_flag", compare_a_flag, 32'h1);
      apb(0, OFF_CTRL0, 0);
      chk("sp_off", rd, 32'h10);
    end
    final_report();
  end
endmodule : testbench
bind ptrc_timer ptrc_timer_monitor ptrc_timer_monitor_i (.*);
`default_nettype wire
